// [shared/pot_map_regs.vh]
// register map constants for the volatile potentiometer register bank
// assumes a 4-bit location address and 9-bit data on the command port
`ifndef POT_MAP_REGS_VH
`define POT_MAP_REGS_VH

`define POT_ADDR_W          4
`define POT_DATA_W          9

`define POT_LOC_WIPER0      4'h0
`define POT_LOC_WIPER1      4'h1
`define POT_LOC_TERM_CTRL   4'h4
`define POT_LOC_RSVD_STAT   4'h5

`define POT_TERM_CTRL_RST   9'h1ff
`define POT_RSVD_STAT_VAL   9'h1f7
`define POT_RSVD_OTHER_VAL  9'h000

// terminal control field positions
`define POT_TC_GENERAL_CALL_ENABLE_BIT     8
`define POT_TC_NET1_HI      7
`define POT_TC_NET1_LO      4
`define POT_TC_NET0_HI      3
`define POT_TC_NET0_LO      0
`define POT_TC_NET1_MASK    9'h0f0
`define POT_TC_NET0_MASK    9'h00f

// command opcodes from the serial protocol engine
`define POT_OP_WRITE        2'h0
`define POT_OP_READ         2'h1
`define POT_OP_INCR         2'h2
`define POT_OP_DECR         2'h3

// default full-scale code of an 8-bit network; mid-scale is half of it
`define POT_FULL_SCALE      9'h100

`endif

// [hw/wiper_cell.v]
// one volatile wiper position register with write, step up and step down
// assumes the caller qualifies the write and step strobes with the serial-enable state
`default_nettype none
`include "pot_map_regs.vh"

module wiper_cell #(
    parameter [8:0] FULL_SCALE = `POT_FULL_SCALE
) (
    input  wire       clk_sys,      // system clock
    input  wire       rst_n,        // synchronous reset, active low
    input  wire       load_mid,     // reload mid-scale after supply recovery
    input  wire       wr_en,        // write strobe
    input  wire [8:0] wr_data,      // write value
    input  wire       incr,         // step toward terminal a
    input  wire       decr,         // step toward terminal b
    output reg  [8:0] position_q    // current wiper code
);

    localparam [8:0] MID_SCALE = {1'b0, FULL_SCALE[8:1]};

    reg [8:0] position_d;

    always @* begin
        position_d = position_q;
        if (load_mid) begin
            position_d = MID_SCALE;
        end else if (wr_en) begin
            // out-of-range writes clamp so the code never leaves the network
            position_d = (wr_data > FULL_SCALE) ? FULL_SCALE : wr_data;
        end else if (incr) begin
            if (position_q < FULL_SCALE) begin
                position_d = position_q + 9'h001;
            end
        end else if (decr) begin
            if (position_q != 9'h000) begin
                position_d = position_q - 9'h001;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            position_q <= MID_SCALE;
        end else begin
            position_q <= position_d;
        end
    end

endmodule // wiper_cell

`default_nettype wire

// [hw/pot_register_bank.v]
// volatile register map of a digital potentiometer with supply-trip handling
// assumes a serial protocol engine drives the command port, one command a strobe,
// and that supply_ok reports the supply above the reset trip point
//
// Functional notes
// - supply recovery reloads wipers to mid-scale
// - every reset sets terminal control to 1ff
// - below trip, serial interface ignores all traffic
// - low supply above trip still executes commands
// - sixteen locations, nine bits, four-bit address
// - wiper0 at 00, wiper1 at 01, control 04
// - location 05 always reads 1f7
// - wiper1 exists only in dual variants
// - each terminal has its own connect bit
// - control write applies when command completes
// - wiper1 lock blocks network 1 control bits
// - wiper0 lock blocks network 0 control bits
// - gc bit 8, net1 bits 7-4, net0 3-0
// - general call enable governs general call handling
`default_nettype none
`include "pot_map_regs.vh"

module pot_register_bank #(
    parameter       DUAL_NET   = 1,                 // 1: two networks, 0: one
    parameter [8:0] FULL_SCALE = `POT_FULL_SCALE    // 9'h100 8-bit, 9'h080 7-bit
) (
    input  wire       clk_sys,          // system clock, 125 MHz
    input  wire       rst_n,            // synchronous reset, active low
    input  wire       supply_ok,        // supply above reset trip point
    input  wire       cmd_valid,        // command strobe from protocol engine
    input  wire [1:0] cmd_op,           // write, read, increment, decrement
    input  wire [3:0] cmd_addr,         // location address
    input  wire [8:0] cmd_wdata,        // write data
    input  wire       cmd_done,         // serial command completed
    input  wire       gc_cmd_valid,     // general call command received
    input  wire       wiper0_lock,      // lock indication for network 0
    input  wire       wiper1_lock,      // lock indication for network 1
    output reg  [8:0] rd_data_q,        // read data
    output reg        rd_valid_q,       // read data valid pulse
    output reg        serial_en_q,      // serial interface enabled
    output reg        gc_accept_q,      // general call accepted pulse
    output reg  [8:0] wiper0_pos_q,     // network 0 wiper code
    output reg  [8:0] wiper1_pos_q,     // network 1 wiper code, zero if single
    output reg        general_call_enable_q,   // applied gc enable
    output reg        net1_shutdown_override_q, // applied network 1 override
    output reg        net1_term_a_connect_q,   // network 1 terminal a switch closed
    output reg        net1_wiper_connect_q,    // network 1 wiper switch closed
    output reg        net1_term_b_connect_q,   // network 1 terminal b switch closed
    output reg        net0_shutdown_override_q, // applied network 0 override
    output reg        net0_term_a_connect_q,   // network 0 terminal a switch closed
    output reg        net0_wiper_connect_q,    // network 0 wiper switch closed
    output reg        net0_term_b_connect_q    // network 0 terminal b switch closed
);

    // merge a control write with the current value, keeping locked nibbles
    function [8:0] merge_control;
        input [8:0] cur;
        input [8:0] wr;
        input       lock0;
        input       lock1;
        reg   [8:0] keep;
        begin
            keep = 9'h000;
            if (lock1) begin
                keep = keep | `POT_TC_NET1_MASK;
            end
            if (lock0) begin
                keep = keep | `POT_TC_NET0_MASK;
            end
            merge_control = (cur & keep) | (wr & ~keep);
        end
    endfunction

    // decode one location; true when it is implemented in this variant
    function is_wiper1;
        input [3:0] addr;
        begin
            is_wiper1 = (addr == `POT_LOC_WIPER1) && (DUAL_NET != 0);
        end
    endfunction

    reg        supply_ok_q;
    reg        load_mid_q;
    reg  [8:0] control_q;       // last write merged past the locks, as seen by reads
    reg  [8:0] control_d;
    reg  [8:0] rd_mux;
    reg        ctl_pending_q;

    wire       cmd_go   = cmd_valid && serial_en_q;
    wire       op_write = cmd_go && (cmd_op == `POT_OP_WRITE);
    wire       op_read  = cmd_go && (cmd_op == `POT_OP_READ);
    wire       op_incr  = cmd_go && (cmd_op == `POT_OP_INCR);
    wire       op_decr  = cmd_go && (cmd_op == `POT_OP_DECR);
    wire       at_w0    = (cmd_addr == `POT_LOC_WIPER0);
    wire       at_w1    = is_wiper1(cmd_addr);
    wire       at_ctl   = (cmd_addr == `POT_LOC_TERM_CTRL);
    wire [8:0] w0_pos;
    wire [8:0] w1_pos;

    // supply tracking: falling disables, rising reloads the defaults
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            supply_ok_q <= 1'b0;
            serial_en_q <= 1'b0;
            load_mid_q  <= 1'b0;
        end else begin
            supply_ok_q <= supply_ok;
            // a one-cycle gap between trip rise and enable lets defaults settle
            load_mid_q  <= supply_ok && !supply_ok_q;
            serial_en_q <= supply_ok && supply_ok_q;
        end
    end

    // no voltage grading above the trip: low supply still runs commands
    wiper_cell #(
        .FULL_SCALE (FULL_SCALE)
    ) u_wiper0 (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .load_mid   (load_mid_q),
        .wr_en      (op_write && at_w0),
        .wr_data    (cmd_wdata),
        .incr       (op_incr && at_w0),
        .decr       (op_decr && at_w0),
        .position_q (w0_pos)
    );

    generate
        if (DUAL_NET != 0) begin : g_dual
            wiper_cell #(
                .FULL_SCALE (FULL_SCALE)
            ) u_wiper1 (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n),
                .load_mid   (load_mid_q),
                .wr_en      (op_write && at_w1),
                .wr_data    (cmd_wdata),
                .incr       (op_incr && at_w1),
                .decr       (op_decr && at_w1),
                .position_q (w1_pos)
            );
        end else begin : g_single
            assign w1_pos = 9'h000;
        end
    endgenerate

    // staged terminal control value
    always @* begin
        control_d = control_q;
        if (load_mid_q) begin
            control_d = `POT_TERM_CTRL_RST;
        end else if (op_write && at_ctl) begin
            control_d = merge_control(control_q, cmd_wdata, wiper0_lock, wiper1_lock);
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            control_q     <= `POT_TERM_CTRL_RST;
            ctl_pending_q <= 1'b0;
        end else begin
            control_q     <= control_d;
            if (load_mid_q) begin
                ctl_pending_q <= 1'b0;
            end else if (op_write && at_ctl) begin
                ctl_pending_q <= 1'b1;
            end else if (cmd_done) begin
                ctl_pending_q <= 1'b0;
            end
        end
    end

    // read multiplexer; every unimplemented location answers a constant
    always @* begin
        case (cmd_addr)
            `POT_LOC_WIPER0:    rd_mux = w0_pos;
            `POT_LOC_TERM_CTRL: rd_mux = control_q;
            `POT_LOC_RSVD_STAT: rd_mux = `POT_RSVD_STAT_VAL;
            default:            rd_mux = `POT_RSVD_OTHER_VAL;
        endcase
        if (at_w1) begin
            rd_mux = w1_pos;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_q  <= 9'h000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= op_read;
            if (op_read) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    // wiper outputs mirror the cells through one register stage
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wiper0_pos_q <= {1'b0, FULL_SCALE[8:1]};
            wiper1_pos_q <= (DUAL_NET != 0) ? {1'b0, FULL_SCALE[8:1]} : 9'h000;
        end else begin
            wiper0_pos_q <= w0_pos;
            wiper1_pos_q <= w1_pos;
        end
    end

    // switches move only at command completion, reset or supply reload so a half-done frame
    // never glitches the analog terminals
    always @(posedge clk_sys) begin
        if (!rst_n || load_mid_q) begin
            general_call_enable_q    <= 1'b1; // gc enable bit of the reset value
            net1_shutdown_override_q <= 1'b1;
            net1_term_a_connect_q    <= 1'b1;
            net1_wiper_connect_q     <= 1'b1;
            net1_term_b_connect_q    <= 1'b1;
            net0_shutdown_override_q <= 1'b1;
            net0_term_a_connect_q    <= 1'b1;
            net0_wiper_connect_q     <= 1'b1;
            net0_term_b_connect_q    <= 1'b1;
        end else if (cmd_done && ctl_pending_q && serial_en_q) begin
            general_call_enable_q    <= control_q[`POT_TC_GENERAL_CALL_ENABLE_BIT];
            net1_shutdown_override_q <= control_q[7];
            net1_term_a_connect_q    <= control_q[6];
            net1_wiper_connect_q     <= control_q[5];
            net1_term_b_connect_q    <= control_q[4];
            net0_shutdown_override_q <= control_q[3];
            net0_term_a_connect_q    <= control_q[2];
            net0_wiper_connect_q     <= control_q[1];
            net0_term_b_connect_q    <= control_q[0];
        end
    end

    // general call acted on only while enabled and the interface is live
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            gc_accept_q <= 1'b0;
        end else begin
            gc_accept_q <= gc_cmd_valid && serial_en_q && general_call_enable_q;
        end
    end

endmodule // pot_register_bank

`default_nettype wire

// [tb/pot_bank_monitor.sv]
// port assertions for the potentiometer register bank
// assumes binding to every pot_register_bank instance
`default_nettype none
module pot_bank_monitor #(
    parameter       DUAL_NET   = 1,
    parameter [8:0] FULL_SCALE = 9'h100
) (
    input wire logic       clk_sys,                  // clock
    input wire logic       rst_n,                    // reset
    input wire logic       supply_ok,                // supply
    input wire logic       cmd_valid,                // strobe
    input wire logic [1:0] cmd_op,                   // opcode
    input wire logic [3:0] cmd_addr,                 // location
    input wire logic       cmd_done,                 // completion
    input wire logic       gc_cmd_valid,             // gc seen
    input wire logic       wiper0_lock,              // lock 0
    input wire logic       wiper1_lock,              // lock 1
    input wire logic [8:0] rd_data_q,                // read data
    input wire logic       rd_valid_q,               // read pulse
    input wire logic       serial_en_q,              // enabled
    input wire logic       gc_accept_q,              // gc pulse
    input wire logic       general_call_enable_q,    // sw 8
    input wire logic       net1_shutdown_override_q, // sw 7
    input wire logic       net1_term_a_connect_q,    // sw 6
    input wire logic       net1_wiper_connect_q,     // sw 5
    input wire logic       net1_term_b_connect_q,    // sw 4
    input wire logic       net0_shutdown_override_q, // sw 3
    input wire logic       net0_term_a_connect_q,    // sw 2
    input wire logic       net0_wiper_connect_q,     // sw 1
    input wire logic       net0_term_b_connect_q     // sw 0
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire [8:0] sw = {general_call_enable_q, net1_shutdown_override_q, net1_term_a_connect_q,
        net1_wiper_connect_q, net1_term_b_connect_q, net0_shutdown_override_q,
        net0_term_a_connect_q, net0_wiper_connect_q, net0_term_b_connect_q};
    wire       rd_take = cmd_valid && serial_en_q && cmd_op == 2'h1;
    // rise seen, then held: reload lands one edge later
    sequence s_up;
        !supply_ok ##1 supply_ok [*3];
    endsequence
    read_pulse_a: assert property (rd_take |=> rd_valid_q)
        else $error("read not answered");
    read_cause_a: assert property (rd_valid_q |-> $past(rd_take))
        else $error("read pulse without accepted read");
    rsvd_read_a: assert property (rd_take && cmd_addr == 4'h5 |=> rd_data_q == 9'h1f7)
        else $error("location 5 wrong");
    supply_off_a: assert property (!supply_ok |=> !serial_en_q)
        else $error("serial stays enabled");
    recover_sw_a: assert property (s_up |-> ##[0:1] (serial_en_q && sw == 9'h1ff))
        else $error("no control reload");
    hold_sw_a: assert property (!cmd_done && serial_en_q |=> $stable(sw))
        else $error("switches moved early");
    lock_net0_a: assert property (wiper0_lock && cmd_done && serial_en_q |=> $stable(sw[3:0]))
        else $error("locked net0 changed");
    lock_net1_a: assert property (wiper1_lock && cmd_done && serial_en_q |=> $stable(sw[7:4]))
        else $error("locked net1 changed");
    gc_gate_a: assert property (gc_accept_q |-> $past(gc_cmd_valid && sw[8]))
        else $error("gc accepted while disabled");
endmodule // pot_bank_monitor
bind pot_register_bank pot_bank_monitor #(.DUAL_NET(DUAL_NET), .FULL_SCALE(FULL_SCALE)) mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .supply_ok(supply_ok), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_done(cmd_done), .gc_cmd_valid(gc_cmd_valid),
    .wiper0_lock(wiper0_lock), .wiper1_lock(wiper1_lock), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .serial_en_q(serial_en_q), .gc_accept_q(gc_accept_q),
    .general_call_enable_q(general_call_enable_q),
    .net1_shutdown_override_q(net1_shutdown_override_q),
    .net1_term_a_connect_q(net1_term_a_connect_q), .net1_wiper_connect_q(net1_wiper_connect_q),
    .net1_term_b_connect_q(net1_term_b_connect_q),
    .net0_shutdown_override_q(net0_shutdown_override_q),
    .net0_term_a_connect_q(net0_term_a_connect_q), .net0_wiper_connect_q(net0_wiper_connect_q),
    .net0_term_b_connect_q(net0_term_b_connect_q));
`default_nettype wire

// [tb/host_model.sv]
// host controller model driving the command port
// assumes falling-edge launch, one command at a time
`default_nettype none
module host_model (
    input  wire logic       clk_sys,      // clock
    input  wire logic       rd_valid_q,   // read pulse
    input  wire logic [8:0] rd_data_q,    // read data
    input  wire logic       gc_accept_q,  // gc pulse
    output var  logic       cmd_valid,    // strobe
    output var  logic [1:0] cmd_op,       // opcode
    output var  logic [3:0] cmd_addr,     // location
    output var  logic [8:0] cmd_wdata,    // data
    output var  logic       cmd_done,     // completion
    output var  logic       gc_cmd_valid  // general call
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_done, gc_cmd_valid} = '0;
    end
    task send(input logic [1:0] op, input logic [3:0] a, input logic [8:0] d,
              output logic v, output logic [8:0] q);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        @(negedge clk_sys);
        v = rd_valid_q;
        q = rd_data_q;
        cmd_valid = 1'b0;
        cmd_wdata = ~d; // released data must not look valid
    endtask
    task done;
        @(negedge clk_sys);
        cmd_done = 1'b1; // two cycles after the write, never with it
        @(negedge clk_sys);
        cmd_done = 1'b0;
    endtask
    task gc(output logic acc);
        @(negedge clk_sys);
        gc_cmd_valid = 1'b1;
        @(negedge clk_sys);
        acc = gc_accept_q;
        gc_cmd_valid = 1'b0;
    endtask
endmodule // host_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the potentiometer register bank
// assumes host_model owns the command port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       supply_ok = 1'b1;
    logic       wiper0_lock = 1'b0;
    logic       wiper1_lock = 1'b0;
    logic       cmd_valid, cmd_done, gc_cmd_valid, rd_valid_q, serial_en_q, gc_accept_q;
    logic [1:0] cmd_op;
    logic [3:0] cmd_addr;
    logic [8:0] cmd_wdata, rd_data_q, wiper0_pos_q, wiper1_pos_q, dq;
    wire  [8:0] sw;
    logic       dv, acc;
    int         errors = 0, cmp_count = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    pot_register_bank #(.DUAL_NET(1), .FULL_SCALE(9'h100)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .supply_ok(supply_ok), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
        .gc_cmd_valid(gc_cmd_valid), .wiper0_lock(wiper0_lock), .wiper1_lock(wiper1_lock),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .serial_en_q(serial_en_q),
        .gc_accept_q(gc_accept_q), .wiper0_pos_q(wiper0_pos_q), .wiper1_pos_q(wiper1_pos_q),
        .general_call_enable_q(sw[8]), .net1_shutdown_override_q(sw[7]),
        .net1_term_a_connect_q(sw[6]), .net1_wiper_connect_q(sw[5]),
        .net1_term_b_connect_q(sw[4]), .net0_shutdown_override_q(sw[3]),
        .net0_term_a_connect_q(sw[2]), .net0_wiper_connect_q(sw[1]),
        .net0_term_b_connect_q(sw[0]));
    host_model host (
        .clk_sys(clk_sys), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
        .gc_accept_q(gc_accept_q), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
        .gc_cmd_valid(gc_cmd_valid));
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [8:0] d);
        host.send(2'h0, a, d, dv, dq);
    endtask
    // a missing read pulse turns into a mismatch
    task rd(input logic [3:0] a, input logic [8:0] e);
        host.send(2'h1, a, 9'h000, dv, dq);
        chk(dv ? dq : ~e, e);
    endtask
    task wait_en;
        int n;
        n = 0;
        while (serial_en_q !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (2) @(negedge clk_sys);
    endtask
    task t_reset;
        wait_en();
        chk(wiper0_pos_q, 9'h080);
        chk(wiper1_pos_q, 9'h080);
        chk(sw, 9'h1ff);
        rd(4'h4, 9'h1ff);
        $display("reset test over");
    endtask
    task t_map;
        wr(4'h0, 9'h033);
        wr(4'h1, 9'h044);
        wr(4'h2, 9'h155);
        wr(4'h5, 9'h000);
        rd(4'h0, 9'h033);
        rd(4'h1, 9'h044);
        rd(4'h2, 9'h000);
        rd(4'h5, 9'h1f7);
        rd(4'hf, 9'h000);
        chk(wiper0_pos_q, 9'h033);
        host.send(2'h2, 4'h0, 9'h000, dv, dq);
        host.send(2'h3, 4'h1, 9'h000, dv, dq);
        rd(4'h0, 9'h034);
        rd(4'h1, 9'h043);
        wr(4'h0, 9'h1ff);
        host.send(2'h2, 4'h0, 9'h000, dv, dq);
        rd(4'h0, 9'h100);
        $display("map test over");
    endtask
    task t_terminal_control;
        wr(4'h4, 9'h0f0);
        rd(4'h4, 9'h0f0);
        chk(sw, 9'h1ff);
        host.done();
        @(negedge clk_sys);
        chk(sw, 9'h0f0);
        host.gc(acc);
        chk({8'h00, acc}, 9'h000);
        wr(4'h4, 9'h1ff);
        host.done();
        host.gc(acc);
        chk({8'h00, acc}, 9'h001);
        wiper0_lock = 1'b1;
        wr(4'h4, 9'h000);
        host.done();
        @(negedge clk_sys);
        chk(sw, 9'h00f);
        wiper0_lock = 1'b0;
        wiper1_lock = 1'b1;
        wr(4'h4, 9'h1ff);
        host.done();
        @(negedge clk_sys);
        chk(sw, 9'h10f);
        wiper1_lock = 1'b0;
        $display("control test over");
    endtask
    task t_brown;
        supply_ok = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({8'h00, serial_en_q}, 9'h000);
        wr(4'h0, 9'h011);
        host.send(2'h1, 4'h0, 9'h000, dv, dq);
        chk({8'h00, dv}, 9'h000);
        supply_ok = 1'b1;
        wait_en();
        chk(wiper0_pos_q, 9'h080);
        chk(sw, 9'h1ff);
        wr(4'h4, 9'h0f0);
        host.done();
        @(negedge clk_sys);
        chk(sw, 9'h0f0);
        $display("supply test over");
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset();
        t_map();
        t_terminal_control();
        t_brown();
        close_out();
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end
endmodule // tb_top
`default_nettype wire
